// ---- verilog/timer_latch_pkg.sv ----
`default_nettype none
package timer_latch_pkg;
  localparam int NUM_COUNTERS = 3;
  // synchronised pin vector layout
  localparam int PIN_WR = 0;
  localparam int PIN_RD = 1;
  localparam int PIN_CS = 2;
  localparam int PIN_A0 = 3;
  localparam int PIN_A1 = 4;
  localparam int PIN_DATA_LSB = 5;
  localparam int PIN_W = 13;
  localparam logic [12:0] PIN_IDLE = 13'h0007;
  localparam logic [1:0] ADDR_CONTROL = 2'h3;
  // control word and read-back command fields
  localparam int CW_SEL_LSB = 6;
  localparam int CW_FMT_LSB = 4;
  localparam logic [1:0] RB_OPCODE = 2'h3;
  localparam int RB_COUNT_N = 5;
  localparam int RB_STATUS_N = 4;
  localparam int RB_SEL_LSB = 1;
  // read/write format codes
  localparam logic [1:0] FMT_LATCH = 2'h0;
  localparam logic [1:0] FMT_LOW_ONLY = 2'h1;
  localparam logic [1:0] FMT_HIGH_ONLY = 2'h2;
  localparam logic [1:0] FMT_BOTH = 2'h3;
  localparam int CFG_FMT_LSB = 4;
  // status byte layout
  localparam int STATUS_OUT_BIT = 7;
  localparam int STATUS_NULL_BIT = 6;
  localparam logic [5:0] CFG_RESET = 6'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
endpackage : timer_latch_pkg
`default_nettype wire

// ---- verilog/counter_latch_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module counter_latch_unit
  import timer_latch_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic reset, // async, active high
  input wire logic [15:0] count_value, // live counting element
  input wire logic out_level, // counter output pin level
  input wire logic ce_load, // holding register moved into element
  input wire logic cw_load, // new control word for this counter
  input wire logic [5:0] cw_cfg, // format, mode and decimal bits
  input wire logic latch_count, // count latch request
  input wire logic latch_status, // status latch request
  input wire logic data_write, // host wrote a count byte
  input wire logic read_done, // host finished reading a byte
  output logic [7:0] read_byte, // byte the next read returns
  output logic null_count // pending-load flag
);
  typedef struct packed {
    logic [5:0] cfg;
    logic null_flag;
    logic count_held;
    logic [15:0] output_latch;
    logic status_held;
    logic [7:0] counter_status_byte;
    logic rd_hi;
    logic wr_hi;
  } unit_state_t;

  unit_state_t st;
  unit_state_t next_st;
  logic [1:0] fmt;
  logic [15:0] src;
  logic hi_sel;

  assign fmt = st.cfg[CFG_FMT_LSB +: 2];
  assign src = st.count_held ? st.output_latch : count_value;
  assign hi_sel = (fmt == FMT_HIGH_ONLY) || ((fmt == FMT_BOTH) && st.rd_hi);
  // pending status goes out ahead of count
  assign read_byte = st.status_held ? st.counter_status_byte
                   : (hi_sel ? src[15:8] : src[7:0]);
  assign null_count = st.null_flag;

  always_comb
  begin
    next_st = st;
    if (cw_load)
    begin
      next_st.cfg = cw_cfg;
      next_st.null_flag = 1'b1;
      next_st.count_held = 1'b0;
      next_st.status_held = 1'b0;
      next_st.rd_hi = 1'b0;
      next_st.wr_hi = 1'b0;
    end
    else
    begin
      if (read_done)
      begin
        if (st.status_held)
          next_st.status_held = 1'b0;
        else if ((fmt == FMT_BOTH) && !st.rd_hi)
          next_st.rd_hi = 1'b1;
        else
        begin
          next_st.rd_hi = 1'b0;
          next_st.count_held = 1'b0;
        end
      end
      // freeze count; only read, never touched
      if (latch_count && !st.count_held)
      begin
        next_st.output_latch = count_value;
        next_st.count_held = 1'b1;
      end
      if (latch_status && !st.status_held)
      begin
        next_st.counter_status_byte = {out_level, st.null_flag, st.cfg};
        next_st.status_held = 1'b1;
      end
      if (ce_load)
        next_st.null_flag = 1'b0;
      // write pointer separate from read pointer
      // second byte of a pair sets the flag
      if (data_write)
      begin
        if ((fmt == FMT_BOTH) && !st.wr_hi)
          next_st.wr_hi = 1'b1;
        else
        begin
          next_st.wr_hi = 1'b0;
          next_st.null_flag = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      st <= '{cfg: CFG_RESET, output_latch: COUNT_ZERO,
              counter_status_byte: BYTE_ZERO, default: 1'b0};
    else
      st <= next_st;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_latch_capture: assert property (
    latch_count && !st.count_held && !cw_load |=>
      st.count_held && st.output_latch == $past(count_value))
    else $error("count not captured");
  a_latch_frozen: assert property (
    st.count_held && !read_done && !cw_load |=>
      $stable(st.output_latch) && st.count_held)
    else $error("held count changed");
  a_status_first: assert property (
    st.status_held && !read_done && !cw_load |=>
      $stable(st.counter_status_byte))
    else $error("held status changed");
  a_status_pin: assert property (
    latch_status && !st.status_held && !cw_load |=>
      read_byte[STATUS_OUT_BIT] == $past(out_level))
    else $error("status output bit wrong");
  a_null_set: assert property (
    cw_load |=> null_count ##0 (!ce_load [*1] or null_count))
    else $error("null count not set");
  a_status_before: assert property (
    st.status_held && st.count_held |-> read_byte == st.counter_status_byte)
    else $error("count served before status");
  c_both_latched: cover property (st.status_held && st.count_held);
endmodule : counter_latch_unit
`default_nettype wire

// ---- verilog/timer_count_latch_readback.sv ----
// Behaviour
// - counter latch command copies live count into that counter's output latch.
// - latching never disturbs the running countdown.
// - latched count holds until read or a new control word.
// - repeated latch before read is ignored; first value kept.
// - two-byte read and write sequencing run independently.
// - read-back bits 3,2,1 select counters 2,1,0; bit 0 is zero.
// - read-back bit 5 low latches count, bit 4 low latches status.
// - read-back may latch several; reading one releases only that one.
// - later read-back count latches before read are ignored.
// - latched status is read through the counter's data location.
// - status bits 5..0 hold format, mode, decimal; bit 6 null count.
// - status bit 7 is output pin level when latched.
// - null count set by control or count write, cleared on load.
// - null count per counter; set on second byte of pair.
// - repeated status latches before read keep the first.
// - both bits low latches count and status together.
// - further latches before the matching read are ignored.
// - control write with bits 7 and 6 high is read-back.
`timescale 1ns/1ps
`default_nettype none
module timer_count_latch_readback
  import timer_latch_pkg::*;
(
  input wire logic clk, // 200 MHz system clock
  input wire logic reset, // async, active high
  input wire logic cs_n, // chip select pin, active low
  input wire logic rd_n, // read strobe pin, active low
  input wire logic wr_n, // write strobe pin, active low
  input wire logic address_bit_low, // address pin 0
  input wire logic address_bit_high, // address pin 1
  input wire logic [7:0] data_in, // data bus from host
  output logic [7:0] data_out, // data bus to host
  output logic data_oe_n, // low while driving the data bus
  input wire logic [NUM_COUNTERS-1:0][15:0] count_value, // live counts
  input wire logic [NUM_COUNTERS-1:0] out_level, // counter output pins
  input wire logic [NUM_COUNTERS-1:0] ce_load, // element load pulses
  output logic [NUM_COUNTERS-1:0] count_write, // count byte written
  output logic [7:0] write_byte, // byte for the holding register
  output logic [NUM_COUNTERS-1:0] null_count // pending-load flags
);
  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] s3;
    logic [PIN_W-1:0] filt;
    logic [7:0] data_out;
    logic oe_n;
    logic [NUM_COUNTERS-1:0] count_write;
    logic [7:0] write_byte;
  } host_state_t;

  host_state_t st;
  host_state_t next_st;
  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] next_filt;
  logic [PIN_W-1:0] disagree;
  logic selected;
  logic wr_end;
  logic rd_start;
  logic rd_end;
  logic [1:0] bus_addr;
  logic [7:0] bus_data;
  logic ctrl_write;
  logic readback;
  logic [1:0] cw_sel;
  logic [1:0] cw_fmt;
  logic [NUM_COUNTERS-1:0] latch_count;
  logic [NUM_COUNTERS-1:0] latch_status;
  logic [NUM_COUNTERS-1:0] cw_load;
  logic [NUM_COUNTERS-1:0] data_write;
  logic [NUM_COUNTERS-1:0] read_done;
  logic [7:0] unit_byte [NUM_COUNTERS];

  assign pins = {data_in, address_bit_high, address_bit_low,
                 cs_n, rd_n, wr_n};

  // a pin change is taken only once the last two stages agree
  assign disagree = st.s2 ^ st.s3;
  assign next_filt = (st.s2 & ~disagree) | (st.filt & disagree);

  // address and data are settled well before the strobe's trailing edge
  assign selected = !st.filt[PIN_CS];
  assign bus_addr = st.filt[PIN_A1:PIN_A0];
  assign bus_data = st.filt[PIN_DATA_LSB +: 8];
  assign wr_end = selected && !st.filt[PIN_WR] && next_filt[PIN_WR];
  assign rd_start = selected && st.filt[PIN_RD] && !next_filt[PIN_RD];
  assign rd_end = selected && !st.filt[PIN_RD] && next_filt[PIN_RD];

  // read-back arrives as a write to the control location
  assign ctrl_write = wr_end && (bus_addr == ADDR_CONTROL);
  // top two bits both high mark a read-back command
  assign readback = ctrl_write
                    && (bus_data[7:6] == RB_OPCODE);
  assign cw_sel = bus_data[CW_SEL_LSB +: 2];
  assign cw_fmt = bus_data[CW_FMT_LSB +: 2];

  // one clock domain, so every property below shares this clock and reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_COUNTERS; gi++)
    begin : gen_counter
      logic rb_hit;
      logic cw_hit;

      // select bits 1..3 map to counters 0..2, bit 0 unused
      assign rb_hit = readback && bus_data[RB_SEL_LSB + gi];
      assign cw_hit = ctrl_write && !readback && (cw_sel == 2'(gi));
      // active-low count bit; both may fire at once
      assign latch_count[gi] = (rb_hit && !bus_data[RB_COUNT_N])
                               || (cw_hit && (cw_fmt == FMT_LATCH));
      assign latch_status[gi] = rb_hit && !bus_data[RB_STATUS_N];
      assign cw_load[gi] = cw_hit && (cw_fmt != FMT_LATCH);
      assign data_write[gi] = wr_end && (bus_addr == 2'(gi));
      assign read_done[gi] = rd_end && (bus_addr == 2'(gi));

      // latch, status and null count kept per counter
      counter_latch_unit u_unit (
        .clk (clk),
        .reset (reset),
        .count_value (count_value[gi]),
        .out_level (out_level[gi]),
        .ce_load (ce_load[gi]),
        .cw_load (cw_load[gi]),
        .cw_cfg (bus_data[5:0]),
        .latch_count (latch_count[gi]),
        .latch_status (latch_status[gi]),
        .data_write (data_write[gi]),
        .read_done (read_done[gi]),
        .read_byte (unit_byte[gi]),
        .null_count (null_count[gi])
      );

      // per counter decode, null count and bus checks, one copy per counter
      a_rb_count_sel: assert property (
        rb_hit && !bus_data[RB_COUNT_N] |-> latch_count[gi])
        else $error("selected count not latched");

      a_rb_status_sel: assert property (
        rb_hit && !bus_data[RB_STATUS_N] |-> latch_status[gi])
        else $error("selected status not latched");

      a_rb_skip_unsel: assert property (
        readback && !bus_data[RB_SEL_LSB + gi] |->
          !latch_count[gi] && !latch_status[gi])
        else $error("unselected counter latched");

      a_latch_cmd: assert property (
        cw_hit && cw_fmt == FMT_LATCH |-> latch_count[gi] && !cw_load[gi])
        else $error("latch command not decoded");

      a_cw_reload: assert property (
        cw_hit && cw_fmt != FMT_LATCH |-> cw_load[gi] && !latch_count[gi])
        else $error("control word not passed to counter");

      a_null_on_cw: assert property (
        cw_load[gi] |=> null_count[gi])
        else $error("control word left null count clear");

      a_null_cleared: assert property (
        ce_load[gi] && !cw_load[gi] && !data_write[gi] |=> !null_count[gi])
        else $error("load left null count set");

      a_write_strobe: assert property (
        data_write[gi] |=> count_write[gi] && write_byte == $past(bus_data))
        else $error("count byte not handed on");

      a_write_route: assert property (
        data_write[gi] |-> bus_addr == 2'(gi) && !ctrl_write)
        else $error("count byte sent to wrong counter");

      a_read_route: assert property (
        rd_start && bus_addr == 2'(gi) |=>
          !data_oe_n && data_out == $past(unit_byte[gi]))
        else $error("read returned another counter byte");
    end
  endgenerate

  always_comb
  begin
    next_st = st;
    next_st.s1 = pins;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.filt = next_filt;
    next_st.count_write = data_write;
    if (wr_end && (bus_addr != ADDR_CONTROL))
      next_st.write_byte = bus_data;
    // data locations return the unit's pending byte: held status, latched count or live count
    if (rd_start && (bus_addr != ADDR_CONTROL))
    begin
      next_st.data_out = unit_byte[bus_addr];
      next_st.oe_n = 1'b0;
    end
    // bus released as soon as strobe or select goes away
    if (next_filt[PIN_RD] || next_filt[PIN_CS])
      next_st.oe_n = 1'b1;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      st <= '{s1: PIN_IDLE, s2: PIN_IDLE, s3: PIN_IDLE, filt: PIN_IDLE,
              data_out: BYTE_ZERO, write_byte: BYTE_ZERO,
              count_write: '0, default: '1};
    else
      st <= next_st;
  end

  assign data_out = st.data_out;
  assign data_oe_n = st.oe_n;
  assign count_write = st.count_write;
  assign write_byte = st.write_byte;

  a_read_drive: assert property (
    rd_start && bus_addr == 2'h0 |=>
      !data_oe_n && data_out == $past(unit_byte[0]))
    else $error("read did not present latch byte");
  a_oe_window: assert property (
    !data_oe_n |-> !st.filt[PIN_RD] && !st.filt[PIN_CS])
    else $error("bus driven outside read");
  a_rb_not_cw: assert property (
    readback |-> cw_load == '0)
    else $error("read-back taken as control word");
  a_rb_select: assert property (
    readback && !bus_data[RB_STATUS_N] |->
      latch_status == bus_data[3:1])
    else $error("read-back selection wrong");
  a_write_pass: assert property (
    data_write[1] |=> count_write == 3'h2 && write_byte == $past(bus_data))
    else $error("count byte not passed on");
  a_latch_no_load: assert property (
    |latch_count |-> cw_load == '0 && data_write == '0)
    else $error("latch disturbed counting state");

  // decode and bus checks shared by all counters
  a_rb_count_off: assert property (
    readback && bus_data[RB_COUNT_N] |-> latch_count == '0)
    else $error("count latched with count bit high");

  a_rb_status_off: assert property (
    readback && bus_data[RB_STATUS_N] |-> latch_status == '0)
    else $error("status latched with status bit high");

  a_cw_no_status: assert property (
    ctrl_write && !readback |-> latch_status == '0)
    else $error("control word latched status");

  a_rb_opcode: assert property (
    readback |-> bus_data[7:6] == RB_OPCODE && bus_addr == ADDR_CONTROL)
    else $error("read-back decoded off the control location");

  a_ctrl_not_data: assert property (
    ctrl_write |-> data_write == '0 && read_done == '0)
    else $error("control write reached a counter");

  a_ctrl_quiet: assert property (
    ctrl_write |=> $stable(write_byte))
    else $error("control write changed the count byte");

  a_one_counter: assert property (
    $onehot0(data_write) && $onehot0(read_done))
    else $error("byte access hit several counters");

  a_pulse_single: assert property (
    |count_write |=> count_write == '0)
    else $error("count write pulse too long");

  a_byte_steady: assert property (
    !wr_end |=> $stable(write_byte))
    else $error("write byte moved without a write");

  a_oe_release: assert property (
    next_filt[PIN_RD] || next_filt[PIN_CS] |=> data_oe_n)
    else $error("bus held after read ended");

  a_oe_follows_read: assert property (
    $fell(data_oe_n) |-> $past(rd_start) && $past(bus_addr) != ADDR_CONTROL)
    else $error("bus driven without a data read");

  a_data_steady: assert property (
    !rd_start |=> $stable(data_out))
    else $error("read data moved without a read");

  a_read_hold: assert property (
    !data_oe_n && !$past(data_oe_n) |-> $stable(data_out))
    else $error("read data changed while driven");

  a_ctrl_read_idle: assert property (
    rd_start && bus_addr == ADDR_CONTROL |=> data_oe_n)
    else $error("control location drove the bus");

  // a glitch shorter than two samples must never reach the decode
  a_pin_agree: assert property (
    ((st.filt ^ $past(st.filt)) & $past(disagree)) == '0)
    else $error("pin change taken before stages agreed");

  c_rb_both: cover property (readback && !bus_data[RB_COUNT_N]
                             && !bus_data[RB_STATUS_N]);
  c_latch_cmd: cover property (cw_load == '0 && |latch_count
                               && !readback);
  c_multi_rb: cover property (readback && &bus_data[3:1]);
  c_read_done: cover property (|read_done);
endmodule : timer_count_latch_readback
`default_nettype wire

// ---- dv/bus_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module bus_host_model
  import timer_latch_pkg::*;
(
  input wire logic clk, // system clock
  output logic cs_n, // chip select
  output logic rd_n, // read strobe
  output logic wr_n, // write strobe
  output logic address_bit_low, // address pin 0
  output logic address_bit_high, // address pin 1
  output logic [7:0] data_in, // data toward device
  input wire logic [7:0] data_out, // data from device
  input wire logic data_oe_n // device drives bus when low
);
  int strobe_len = 5; // raised by the bench to act as a slow host
  initial
  begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    {address_bit_high, address_bit_low} = 2'h0;
    data_in = 8'h00;
  end
  // released lines flip so a stale value is never mistaken for data
  task automatic release_bus();
    cs_n = 1'b1;
    data_in = ~data_in;
    {address_bit_high, address_bit_low} = ~{address_bit_high, address_bit_low};
  endtask : release_bus
  task automatic setup(input logic [1:0] addr);
    @(negedge clk);
    cs_n = 1'b0;
    {address_bit_high, address_bit_low} = addr;
    repeat (5) @(negedge clk);
  endtask : setup
  task automatic bus_write(input logic [1:0] addr, input logic [7:0] value);
    data_in = value;
    setup(addr);
    wr_n = 1'b0;
    repeat (strobe_len) @(negedge clk);
    wr_n = 1'b1;
    repeat (5) @(negedge clk);
    release_bus();
    repeat (8) @(negedge clk);
  endtask : bus_write
  task automatic control_write(input logic [7:0] value);
    bus_write(ADDR_CONTROL, {value[7:1], 1'b0});
  endtask : control_write
  task automatic bus_read(input logic [1:0] addr, output logic [7:0] value,
                          output logic seen);
    setup(addr);
    rd_n = 1'b0;
    // sampled at the falling edge, half a cycle after the outputs settle
    repeat (strobe_len + 4) @(negedge clk);
    seen = (data_oe_n === 1'b0);
    value = data_out;
    rd_n = 1'b1;
    repeat (6) @(negedge clk);
    release_bus();
    repeat (6) @(negedge clk);
  endtask : bus_read
endmodule : bus_host_model
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import timer_latch_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cs_n, rd_n, wr_n, a_lo, a_hi;
  logic [7:0] data_in, data_out, write_byte, last_byte;
  logic data_oe_n;
  logic [NUM_COUNTERS-1:0][15:0] count_value;
  logic [NUM_COUNTERS-1:0] out_level;
  logic [NUM_COUNTERS-1:0] ce_load;
  logic [NUM_COUNTERS-1:0] count_write, null_count, last_sel;
  int mismatches = 0;
  int compares = 0;
  int writes_seen = 0;
  always #2.5 clk = ~clk;
  timer_count_latch_readback dut_u (.clk(clk), .reset(reset), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .address_bit_low(a_lo),
    .address_bit_high(a_hi), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .count_value(count_value),
    .out_level(out_level), .ce_load(ce_load), .count_write(count_write),
    .write_byte(write_byte), .null_count(null_count));
  bus_host_model host_u (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .address_bit_low(a_lo), .address_bit_high(a_hi), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n));
  always @(posedge clk)
  begin
    if (|count_write === 1'b1)
    begin
      writes_seen++;
      last_byte <= write_byte;
      last_sel <= count_write;
    end
  end
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] expect_v);
    compares++;
    if (seen !== expect_v)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, expect_v, seen);
    end
  endtask : check
  task automatic rd(input logic [1:0] addr, input logic [7:0] exp_v);
    logic [7:0] v;
    logic ok;
    host_u.bus_read(addr, v, ok);
    check("read drive", {15'h0000, ok}, 16'h0001);
    if (ok !== 1'b1)
      end_of_test();
    check("read byte", {8'h00, v}, {8'h00, exp_v});
  endtask : rd
  task automatic pulse_load(input logic [NUM_COUNTERS-1:0] mask);
    @(negedge clk);
    ce_load = mask;
    @(negedge clk);
    ce_load = '0;
    repeat (2) @(negedge clk);
  endtask : pulse_load
  task automatic test_null();
    host_u.control_write(8'h34);
    check("null0", {15'h0000, null_count[0]}, 16'h0001);
    check("null21", {14'h0000, null_count[2:1]}, 16'h0000);
    pulse_load(3'b001);
    check("null0", {15'h0000, null_count[0]}, 16'h0000);
    host_u.bus_write(2'h0, 8'hAB);
    check("null0", {15'h0000, null_count[0]}, 16'h0000);
    check("wbyte", {8'h00, last_byte}, 16'h00AB);
    host_u.bus_write(2'h0, 8'hCD);
    check("null0", {15'h0000, null_count[0]}, 16'h0001);
    pulse_load(3'b001);
    $display("null flag test done");
  endtask : test_null
  task automatic test_latch();
    count_value[0] = 16'h1234;
    host_u.control_write(8'h00);
    count_value[0] = 16'h5678;
    host_u.control_write(8'h00);
    rd(2'h0, 8'h34);
    host_u.bus_write(2'h0, 8'h11);
    rd(2'h0, 8'h12);
    host_u.bus_write(2'h0, 8'h22);
    check("wbyte", {8'h00, last_byte}, 16'h0022);
    check("wcount", writes_seen[15:0], 16'h0004);
    host_u.control_write(8'h00);
    rd(2'h0, 8'h78);
    rd(2'h0, 8'h56);
    $display("latch command test done");
  endtask : test_latch
  task automatic test_readback();
    host_u.strobe_len = 9;
    host_u.control_write(8'h56);
    out_level = 3'b001;
    count_value[0] = 16'hA1B2;
    count_value[1] = 16'hC3D4;
    host_u.control_write(8'hC6);
    out_level = 3'b010;
    count_value[0] = 16'h0F1E;
    host_u.control_write(8'hC6);
    rd(2'h1, 8'h56);
    rd(2'h1, 8'hD4);
    rd(2'h0, 8'hF4);
    rd(2'h0, 8'hB2);
    rd(2'h0, 8'hA1);
    host_u.control_write(8'hD2);
    host_u.control_write(8'hE4);
    rd(2'h1, 8'hD6);
    rd(2'h0, 8'h1E);
    rd(2'h0, 8'h0F);
    host_u.strobe_len = 5;
    $display("read-back test done");
  endtask : test_readback
  task automatic test_counter_two();
    host_u.control_write(8'hB0);
    check("null2", {15'h0000, null_count[2]}, 16'h0001);
    host_u.bus_write(2'h1, 8'h5A);
    check("wsel", {13'h0000, last_sel}, 16'h0002);
    check("wbyte", {8'h00, last_byte}, 16'h005A);
    pulse_load(3'b110);
    check("null21", {14'h0000, null_count[2:1]}, 16'h0000);
    out_level = 3'b100;
    count_value[2] = 16'h9C8D;
    host_u.control_write(8'hC8);
    count_value[2] = 16'h7E6F;
    out_level = 3'b000;
    rd(2'h2, 8'hB0);
    rd(2'h2, 8'h8D);
    rd(2'h2, 8'h9C);
    $display("counter two test done");
  endtask : test_counter_two
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
  initial
  begin
    count_value = '0;
    out_level = '0;
    ce_load = '0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    check("oe idle", {15'h0000, data_oe_n}, 16'h0001);
    check("null rst", {13'h0000, null_count}, 16'h0000);
    check("cw rst", {13'h0000, count_write}, 16'h0000);
    $display("reset test done");
    test_null();
    test_latch();
    test_readback();
    test_counter_two();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
